// >>> include/issc_pkg.sv
/*
  Shared constants, types and register layout of the two-wire slave
  status and control block.
  Assumes a single core clock and a synchronous active-high reset.
*/
package issc_pkg;

  // Register byte offsets on the Avalon-MM slave
  localparam logic [4:0] OFS_STATUS_CTRL = 5'h00;
  localparam logic [4:0] OFS_SLAVE_ADDR = 5'h04;
  localparam logic [4:0] OFS_DATA = 5'h08;
  localparam logic [4:0] OFS_IRQ_STATUS = 5'h0C;
  localparam logic [4:0] OFS_IRQ_MASK = 5'h10;

  // Bit positions inside the status and control register
  localparam int BIT_BYTE_DONE = 7;
  localparam int BIT_ADDR_MATCH = 6;
  localparam int BIT_BUS_BUSY = 5;
  localparam int BIT_TX_SELECT = 4;
  localparam int BIT_ACK_DRIVE = 3;
  localparam int BIT_MASTER_READ = 2;
  localparam int BIT_RUN_NO_SYSCLK = 1;
  localparam int BIT_ACK_RECEIVED = 0;

  // Interrupt status and mask bit positions
  localparam int IRQ_BYTE_DONE = 0;
  localparam int IRQ_ADDR_MATCH = 1;
  localparam int IRQ_WIDTH = 2;

  // Reset values
  localparam logic [7:0] RST_STATUS_CTRL = 8'h81;
  localparam logic [7:0] RST_SLAVE_ADDR = 8'h00;
  localparam logic [7:0] RST_DATA = 8'h00;
  localparam logic [IRQ_WIDTH-1:0] RST_IRQ = 2'h0;

  // Bits per byte and the count that marks a full byte
  localparam int BYTE_BITS = 8;
  localparam logic [3:0] CNT_FULL = 4'h8;

  // Field layout of the status and control register, bit 7 first
  typedef struct packed {
    logic byte_done_flag;
    logic addr_match_flag;
    logic bus_busy_flag;
    logic tx_select;
    logic ack_drive_ctrl;
    logic master_read_flag;
    logic run_without_sysclk;
    logic ack_received_flag;
  } issc_ctrl_t;

  // Synchronised bus line levels
  typedef struct packed {
    logic scl;
    logic sda;
  } issc_lines_t;

  typedef enum logic [6:0] {
    S_IDLE = 7'h01,
    S_ADDR = 7'h02,
    S_ACK_A = 7'h04,
    S_RX = 7'h08,
    S_ACK_RX = 7'h10,
    S_TX = 7'h20,
    S_ACK_TX = 7'h40
  } issc_state_t;

endpackage : issc_pkg

// >>> src/issc_sync.sv
/*
  Three-stage input synchroniser with agreement filter.
  Assumes inputs arrive from outside the core clock domain.
*/
module issc_sync
  import issc_pkg::*;
#(
  parameter int WIDTH = 2,
  parameter logic [WIDTH-1:0] INIT = '1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta <= INIT;
      stage2 <= INIT;
      stage3 <= INIT;
    end else begin
      meta <= d;
      stage2 <= meta;
      stage3 <= stage2;
    end
  end

  // Output moves only once stages two and three agree
  always_ff @(posedge clk) begin
    if (rst) begin
      q <= INIT;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (stage2[i] == stage3[i]) begin
          q[i] <= stage3[i];
        end
      end
    end
  end

endmodule : issc_sync

// >>> src/issc_top.sv
/*
  Slave-only two-wire interface: status and control register, address
  match, byte shifting, acknowledge drive and capture, interrupts.
  Assumes an external master drives SCL; SDA is open drain with a
  pull-up outside; registers reached over Avalon-MM with waitrequest.
*/
//Contract
//[R1] Byte-done flag rises and interrupts when eight bits complete; low mid-byte.
//[R2] Address-match flag high when received address equals stored address, else low.
//[R3] Direction bit one stored as master-read flag; slave should transmit.
//[R4] Direction bit zero clears master-read flag; slave should receive.
//[R5] Run-without-sysclk set keeps interface and interrupt working in low power.
//[R6] Halted with run-without-sysclk set: reception works, transmission disabled.
//[R7] Acknowledge seen on ninth clock after transmit clears ack-received flag.
//[R8] No acknowledge after transmitted byte sets ack-received flag.
//[R9] START condition on the bus sets the bus-busy flag.
//[R10] Transmitter continues on acknowledge; on missing acknowledge releases data line.
//[R11] Receiver drives ack-drive control value on SDA during ninth clock.
module issc_top
  import issc_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  input wire logic [4:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic CPU_HALT,
  input wire logic SCL_I,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE,
  output logic IRQ
);

  function automatic logic addr_eq(input logic [7:0] rx, input logic [7:0] own);
    addr_eq = (rx[7:1] == own[7:1]);
  endfunction : addr_eq

  issc_ctrl_t ctrl;
  issc_state_t st;
  issc_lines_t lines_q;
  issc_lines_t lines_d;
  logic [7:0] slave_addr;
  logic [7:0] tx_data;
  logic [7:0] rx_data;
  logic [7:0] shreg;
  logic [3:0] cnt;
  logic [IRQ_WIDTH-1:0] irq_st;
  logic [IRQ_WIDTH-1:0] irq_mask;
  logic active;
  logic tx_ok;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic byte_end;
  logic addr_hit;
  logic byte_done_evt;
  logic addr_evt;
  logic bus_wr;
  logic [7:0] wdat;

  issc_sync #(
    .WIDTH(2),
    .INIT(2'h3)
  ) u_sync (
    .clk(CORE_CLK),
    .rst(SYS_RST),
    .d({SCL_I, SDA_I}),
    .q(lines_q)
  );

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      lines_d <= 2'h3;
    end else begin
      lines_d <= lines_q;
    end
  end

  // [R5] Clock-source gating
  // Without run_without_sysclk a halted core stops the interface
  assign active = ~(CPU_HALT & ~ctrl.run_without_sysclk);
  // [R6] Transmit needs the system clock
  assign tx_ok = ctrl.tx_select & ~(CPU_HALT & ctrl.run_without_sysclk);

  assign scl_rise = active & lines_q.scl & ~lines_d.scl;
  assign scl_fall = active & ~lines_q.scl & lines_d.scl;
  assign start_det = active & lines_q.scl & lines_d.scl & lines_d.sda & ~lines_q.sda;
  assign stop_det = active & lines_q.scl & lines_d.scl & ~lines_d.sda & lines_q.sda;
  assign byte_end = scl_fall & (cnt == CNT_FULL);
  assign addr_hit = addr_eq(shreg, slave_addr);
  assign addr_evt = byte_end & (st == S_ADDR) & addr_hit;
  assign byte_done_evt = addr_evt | (byte_end & ((st == S_RX) | (st == S_TX)));

  // Byte-level state machine
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      st <= S_IDLE;
      cnt <= 4'h0;
      shreg <= 8'h00;
      SDA_OE <= 1'b0;
    end else if (start_det) begin
      st <= S_ADDR;
      cnt <= 4'h0;
      SDA_OE <= 1'b0;
    end else if (stop_det) begin
      st <= S_IDLE;
      cnt <= 4'h0;
      SDA_OE <= 1'b0;
    end else begin
      case (st)
        S_IDLE: begin
          SDA_OE <= 1'b0;
        end
        S_ADDR: begin
          if (scl_rise) begin
            shreg <= {shreg[6:0], lines_q.sda};
            cnt <= cnt + 4'h1;
          end else if (byte_end) begin
            cnt <= 4'h0;
            // [R2] Acknowledge own address only
            if (addr_hit) begin
              st <= S_ACK_A;
              SDA_OE <= 1'b1;
            end else begin
              st <= S_IDLE;
            end
          end
        end
        S_ACK_A: begin
          if (scl_fall) begin
            cnt <= 4'h0;
            // [R3] Read request turns to transmit
            if (shreg[0]) begin
              st <= S_TX;
              shreg <= tx_data;
              SDA_OE <= tx_ok & ~tx_data[7];
            end else begin
              st <= S_RX;
              SDA_OE <= 1'b0;
            end
          end
        end
        S_RX: begin
          if (scl_rise) begin
            shreg <= {shreg[6:0], lines_q.sda};
            cnt <= cnt + 4'h1;
          end else if (byte_end) begin
            cnt <= 4'h0;
            st <= S_ACK_RX;
            // [R11] Drive ack level on ninth clock
            SDA_OE <= ~ctrl.ack_drive_ctrl;
          end
        end
        S_ACK_RX: begin
          if (scl_fall) begin
            st <= S_RX;
            SDA_OE <= 1'b0;
          end
        end
        S_TX: begin
          if (scl_rise) begin
            cnt <= cnt + 4'h1;
          end else if (byte_end) begin
            cnt <= 4'h0;
            st <= S_ACK_TX;
            SDA_OE <= 1'b0;
          end else if (scl_fall) begin
            shreg <= {shreg[6:0], 1'b0};
            // [R6] Data bits held off when halted
            SDA_OE <= tx_ok & ~shreg[6];
          end
        end
        S_ACK_TX: begin
          if (scl_fall) begin
            // [R10] Continue on ack, release on none
            if (!ctrl.ack_received_flag) begin
              st <= S_TX;
              shreg <= tx_data;
              SDA_OE <= tx_ok & ~tx_data[7];
            end else begin
              st <= S_IDLE;
              SDA_OE <= 1'b0;
            end
          end
        end
        default: begin
          st <= S_IDLE;
          SDA_OE <= 1'b0;
        end
      endcase
    end
  end

  // Open drain: only ever pulls low
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      SDA_O <= 1'b0;
    end else begin
      SDA_O <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      rx_data <= RST_DATA;
    end else if (byte_end && st == S_RX) begin
      rx_data <= shreg;
    end
  end

  assign bus_wr = AVS_WRITE & ~AVS_WAITREQUEST & AVS_BYTEENABLE[0];
  assign wdat = AVS_WRITEDATA[7:0];

  // Hardware status flags
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      ctrl.byte_done_flag <= RST_STATUS_CTRL[BIT_BYTE_DONE];
      ctrl.addr_match_flag <= RST_STATUS_CTRL[BIT_ADDR_MATCH];
      ctrl.bus_busy_flag <= RST_STATUS_CTRL[BIT_BUS_BUSY];
      ctrl.master_read_flag <= RST_STATUS_CTRL[BIT_MASTER_READ];
      ctrl.ack_received_flag <= RST_STATUS_CTRL[BIT_ACK_RECEIVED];
    end else begin
      // [R9] START marks the bus busy
      if (start_det) begin
        ctrl.bus_busy_flag <= 1'b1;
      end else if (stop_det) begin
        ctrl.bus_busy_flag <= 1'b0;
      end
      // [R1] Byte done set at end, cleared while shifting
      if (byte_done_evt) begin
        ctrl.byte_done_flag <= 1'b1;
      end else if (start_det || (scl_rise && (st == S_RX || st == S_TX))) begin
        ctrl.byte_done_flag <= 1'b0;
      end
      // [R2] Address compare result
      if (start_det) begin
        ctrl.addr_match_flag <= 1'b0;
      end else if (byte_end && st == S_ADDR) begin
        ctrl.addr_match_flag <= addr_hit;
      end else if (byte_end && (st == S_RX || st == S_TX)) begin
        ctrl.addr_match_flag <= 1'b0;
      end
      // [R3] [R4] Direction bit capture
      if (addr_evt) begin
        ctrl.master_read_flag <= shreg[0];
      end
      // [R7] [R8] Ninth-clock acknowledge sample
      if (scl_rise && st == S_ACK_TX) begin
        ctrl.ack_received_flag <= lines_q.sda;
      end
    end
  end

  // Software-owned control bits and registers
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      ctrl.tx_select <= RST_STATUS_CTRL[BIT_TX_SELECT];
      ctrl.ack_drive_ctrl <= RST_STATUS_CTRL[BIT_ACK_DRIVE];
      ctrl.run_without_sysclk <= RST_STATUS_CTRL[BIT_RUN_NO_SYSCLK];
      slave_addr <= RST_SLAVE_ADDR;
      tx_data <= RST_DATA;
      irq_mask <= RST_IRQ;
    end else if (bus_wr) begin
      case (AVS_ADDRESS)
        OFS_STATUS_CTRL: begin
          ctrl.tx_select <= wdat[BIT_TX_SELECT];
          ctrl.ack_drive_ctrl <= wdat[BIT_ACK_DRIVE];
          ctrl.run_without_sysclk <= wdat[BIT_RUN_NO_SYSCLK];
        end
        OFS_SLAVE_ADDR: begin
          slave_addr <= {wdat[7:1], 1'b0};
        end
        OFS_DATA: begin
          tx_data <= wdat;
        end
        OFS_IRQ_MASK: begin
          irq_mask <= wdat[IRQ_WIDTH-1:0];
        end
        default: begin
          tx_data <= tx_data;
        end
      endcase
    end
  end

  // Sticky events; a new event beats a same-cycle clear
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      irq_st <= RST_IRQ;
    end else begin
      for (int i = 0; i < IRQ_WIDTH; i++) begin
        if (bus_wr && AVS_ADDRESS == OFS_IRQ_STATUS && wdat[i]) begin
          irq_st[i] <= 1'b0;
        end
      end
      if (byte_done_evt) begin
        irq_st[IRQ_BYTE_DONE] <= 1'b1;
      end
      if (addr_evt) begin
        irq_st[IRQ_ADDR_MATCH] <= 1'b1;
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(irq_st & irq_mask);
    end
  end

  // One wait cycle per access; read data loaded with the answer
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA <= 32'h0000_0000;
    end else begin
      if (AVS_WAITREQUEST && (AVS_READ || AVS_WRITE)) begin
        AVS_WAITREQUEST <= 1'b0;
      end else begin
        AVS_WAITREQUEST <= 1'b1;
      end
      if (AVS_WAITREQUEST && AVS_READ) begin
        case (AVS_ADDRESS)
          OFS_STATUS_CTRL: AVS_READDATA <= {24'h000000, ctrl};
          OFS_SLAVE_ADDR: AVS_READDATA <= {24'h000000, slave_addr};
          OFS_DATA: AVS_READDATA <= {24'h000000, rx_data};
          OFS_IRQ_STATUS: AVS_READDATA <= {30'h0000_0000, irq_st};
          OFS_IRQ_MASK: AVS_READDATA <= {30'h0000_0000, irq_mask};
          default: AVS_READDATA <= 32'h0000_0000;
        endcase
      end
    end
  end

  property p_byte_done_irq;
    @(posedge CORE_CLK) disable iff (SYS_RST)
      byte_done_evt |=> ctrl.byte_done_flag && irq_st[IRQ_BYTE_DONE];
  endproperty
  a_byte_done_irq: assert property (p_byte_done_irq) // [R1]
    else $error("byte done flag or interrupt missing");

  property p_byte_done_low;
    @(posedge CORE_CLK) disable iff (SYS_RST)
      (st == S_RX && cnt > 4'h1 && cnt < CNT_FULL) |-> !ctrl.byte_done_flag;
  endproperty
  a_byte_done_low: assert property (p_byte_done_low) // [R1]
    else $error("byte done flag high mid byte");

  property p_addr_match;
    @(posedge CORE_CLK) disable iff (SYS_RST)
      (byte_end && st == S_ADDR && !start_det && !stop_det) |=> ctrl.addr_match_flag == $past(addr_hit);
  endproperty
  a_addr_match: assert property (p_addr_match) // [R2]
    else $error("address match flag wrong");

  property p_master_read;
    @(posedge CORE_CLK) disable iff (SYS_RST)
      (addr_evt && shreg[0] && !start_det && !stop_det) |=> ctrl.master_read_flag ##1 1'b1;
  endproperty
  a_master_read: assert property (p_master_read) // [R3]
    else $error("master read flag not set");

  property p_master_write;
    @(posedge CORE_CLK) disable iff (SYS_RST)
      (addr_evt && !shreg[0] && !start_det && !stop_det) |=> !ctrl.master_read_flag;
  endproperty
  a_master_write: assert property (p_master_write) // [R4]
    else $error("master read flag not cleared");

  property p_rx_runs;
    @(posedge CORE_CLK) disable iff (SYS_RST)
      (ctrl.run_without_sysclk && st == S_RX && scl_rise && cnt < CNT_FULL && !start_det)
        |=> cnt == $past(cnt) + 4'h1;
  endproperty
  a_rx_runs: assert property (p_rx_runs) // [R5]
    else $error("reception stalled");

  property p_halt_no_tx;
    @(posedge CORE_CLK) disable iff (SYS_RST)
      (CPU_HALT && ctrl.run_without_sysclk && st == S_TX) [*2] |-> !SDA_OE;
  endproperty
  a_halt_no_tx: assert property (p_halt_no_tx) // [R6]
    else $error("transmit while halted");

  property p_ack_seen;
    @(posedge CORE_CLK) disable iff (SYS_RST)
      (st == S_ACK_TX && scl_rise && !lines_q.sda) |=> !ctrl.ack_received_flag;
  endproperty
  a_ack_seen: assert property (p_ack_seen) // [R7]
    else $error("ack received flag not cleared");

  property p_nack_seen;
    @(posedge CORE_CLK) disable iff (SYS_RST)
      (st == S_ACK_TX && scl_rise && lines_q.sda) |=> ctrl.ack_received_flag;
  endproperty
  a_nack_seen: assert property (p_nack_seen) // [R8]
    else $error("ack received flag not set");

  property p_busy;
    @(posedge CORE_CLK) disable iff (SYS_RST)
      start_det |=> ctrl.bus_busy_flag && st == S_ADDR;
  endproperty
  a_busy: assert property (p_busy) // [R9]
    else $error("bus busy not set on start");

  property p_release;
    @(posedge CORE_CLK) disable iff (SYS_RST)
      (st == S_ACK_TX && scl_fall && ctrl.ack_received_flag && !start_det && !stop_det)
        |=> (st == S_IDLE && !SDA_OE) [*2];
  endproperty
  a_release: assert property (p_release) // [R10]
    else $error("data line not released after nack");

  property p_ack_drive;
    @(posedge CORE_CLK) disable iff (SYS_RST)
      (st == S_RX && byte_end && !start_det && !stop_det)
        |=> st == S_ACK_RX && SDA_OE == !$past(ctrl.ack_drive_ctrl);
  endproperty
  a_ack_drive: assert property (p_ack_drive) // [R11]
    else $error("ack drive level wrong");

endmodule : issc_top

// >>> dv/issc_master.sv
/*
  Behavioural two-wire bus master: drives the serial clock and pulls the data wire.
  Assumes the bench resolves the open-drain data wire with a pull-up.
*/
module issc_master (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_pull,
  output logic [7:0] res,
  output logic res_vld
);
  timeunit 1ns;
  timeprecision 1ps;
  // Quarter of a 160 ns link period in 8 ns core cycles
  localparam int QTR = 5;

  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
    res = 8'h00;
    res_vld = 1'b0;
  end

  task automatic wait_q(input int n);
    repeat (n * QTR) @(posedge clk);
  endtask : wait_q

  task automatic post(input logic [7:0] v);
    res <= v;
    res_vld <= 1'b1;
    @(posedge clk);
    res_vld <= 1'b0;
  endtask : post

  // Clock stands high outside frames
  task automatic start();
    sda_pull <= 1'b1;
    wait_q(2);
    scl <= 1'b0;
    wait_q(1);
  endtask : start

  task automatic stop();
    sda_pull <= 1'b1;
    wait_q(1);
    scl <= 1'b1;
    wait_q(2);
    sda_pull <= 1'b0;
    wait_q(2);
  endtask : stop

  // Data changes mid low phase, sampled as the clock falls
  task automatic bit_cycle(input logic b, output logic s);
    sda_pull <= ~b;
    wait_q(1);
    scl <= 1'b1;
    wait_q(2);
    s = sda;
    scl <= 1'b0;
    wait_q(1);
  endtask : bit_cycle

  task automatic wr_byte(input logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_cycle(d[i], s);
    bit_cycle(1'b1, s);
    post({7'h00, s});
  endtask : wr_byte

  task automatic rd_byte(input logic nack);
    logic [7:0] d;
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(1'b1, s);
      d[i] = s;
    end
    bit_cycle(nack, s);
    sda_pull <= 1'b0;
    post(d);
  endtask : rd_byte
endmodule : issc_master

// >>> dv/issc_top_test.sv
/*
  Self-checking bench for the two-wire slave status and control block.
  Assumes issc_master as bus master and a pull-up on the data wire.
*/
module issc_top_test
  import issc_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk;
  logic sys_rst;
  logic [4:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic cpu_halt;
  logic sda_oe;
  logic sda_o;
  logic irq;
  logic scl;
  logic m_pull;
  logic [7:0] m_res;
  logic m_res_vld;
  logic [7:0] b;
  // Open drain with pull-up: the slave's level counts only while enabled
  wire sda = ~m_pull & (sda_oe ? sda_o : 1'b1);
  int error_cnt = 0;
  int n_checks = 0;
  logic [15:0] reg_q[$];
  logic [7:0] link_q[$];

  issc_top dut (
    .CORE_CLK(core_clk), .SYS_RST(sys_rst), .AVS_ADDRESS(avs_address),
    .AVS_READ(avs_read), .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata),
    .AVS_BYTEENABLE(4'hF), .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest),
    .CPU_HALT(cpu_halt), .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE(sda_oe), .IRQ(irq)
  );
  issc_master m (
    .clk(core_clk), .sda(sda), .scl(scl), .sda_pull(m_pull), .res(m_res), .res_vld(m_res_vld)
  );

  always #4 core_clk = ~core_clk;

  task automatic close_out();
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : close_out

  task automatic fail(input logic [7:0] e, input logic [7:0] g);
    error_cnt++;
    $display("ERROR at %0t: expected %0h got %0h", $time, e, g);
  endtask : fail

  task automatic cmp_reg(input logic [15:0] note, input logic [7:0] got);
    n_checks++;
    if ((got & note[15:8]) !== note[7:0]) fail(note[7:0], got);
  endtask : cmp_reg

  task automatic cmp_link(input logic [7:0] e, input logic [7:0] got);
    n_checks++;
    if (got !== e) fail(e, got);
  endtask : cmp_link

  task automatic cmp_irq(input logic e);
    repeat (2) @(posedge core_clk);
    cmp_link({7'h00, e}, {7'h00, irq});
  endtask : cmp_irq

  // Request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    avs_read <= ~wr;
    avs_write <= wr;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0) @(posedge core_clk);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge core_clk);
  endtask : bus

  task automatic rd(input logic [4:0] a, input logic [7:0] e, input logic [7:0] mask);
    reg_q.push_back({mask, e});
    bus(1'b0, a, 8'h00);
  endtask : rd

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic send(input logic [7:0] d, input logic [7:0] ack);
    link_q.push_back(ack);
    m.wr_byte(d);
  endtask : send

  task automatic recv(input logic nack, input logic [7:0] e);
    link_q.push_back(e);
    m.rd_byte(nack);
  endtask : recv

  always @(posedge core_clk) begin
    if (avs_read && avs_waitrequest === 1'b0) cmp_reg(reg_q.pop_front(), avs_readdata[7:0]);
    if (m_res_vld) cmp_link(link_q.pop_front(), m_res);
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    close_out();
  end

  initial begin
    core_clk = 1'b0;
    sys_rst = 1'b1;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h00000000;
    cpu_halt = 1'b0;
    void'($urandom(96516));
    repeat (3) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    rd(OFS_STATUS_CTRL, 8'h81, 8'hFF); // Reset value
    rd(5'h14, 8'h00, 8'hFF);
    wr(OFS_STATUS_CTRL, 8'hFF);
    rd(OFS_STATUS_CTRL, 8'h9B, 8'hFF); // Flags read only
    wr(OFS_STATUS_CTRL, 8'h00);
    wr(OFS_SLAVE_ADDR, 8'hB4);
    wr(OFS_IRQ_MASK, 8'h03);
    m.start();
    rd(OFS_STATUS_CTRL, 8'h20, 8'h20); // Busy after start
    send({7'h5A, 1'b0}, 8'h00); // Ack on match
    rd(OFS_STATUS_CTRL, 8'hC0, 8'hC4); // Match and write
    cmp_irq(1'b1); // Interrupt raised
    rd(OFS_IRQ_STATUS, 8'h03, 8'hFF); // Both events sticky
    wr(OFS_IRQ_MASK, 8'h00);
    cmp_irq(1'b0); // Masked
    wr(OFS_IRQ_MASK, 8'h03);
    wr(OFS_IRQ_STATUS, 8'h03);
    cmp_irq(1'b0); // Cleared by a one
    b = 8'($urandom);
    fork
      send(b, 8'h00); // Ack driven
      begin
        repeat (50) @(posedge core_clk);
        rd(OFS_STATUS_CTRL, 8'h00, 8'h80); // Low mid byte
      end
    join
    rd(OFS_DATA, b, 8'hFF); // Byte received
    rd(OFS_STATUS_CTRL, 8'h80, 8'h80); // Set after byte
    wr(OFS_STATUS_CTRL, 8'h08);
    send(~b, 8'h01); // No ack driven
    m.stop();
    rd(OFS_STATUS_CTRL, 8'h00, 8'h20); // Idle after stop
    m.start();
    send({7'h33, 1'b0}, 8'h01); // No ack on mismatch
    rd(OFS_STATUS_CTRL, 8'h00, 8'h40); // Flag low
    m.stop();
    b = 8'($urandom);
    wr(OFS_STATUS_CTRL, 8'h10);
    wr(OFS_DATA, b);
    m.start();
    send({7'h5A, 1'b1}, 8'h00); // Read address acked
    rd(OFS_STATUS_CTRL, 8'h44, 8'h44); // Master read
    recv(1'b0, b); // First byte
    rd(OFS_STATUS_CTRL, 8'h00, 8'h01); // Ack seen
    recv(1'b1, b); // Continues after ack
    rd(OFS_STATUS_CTRL, 8'h01, 8'h01); // No ack seen
    repeat (20) @(posedge core_clk);
    cmp_link(8'h00, {7'h00, sda_oe}); // Line released
    m.stop();
    wr(OFS_IRQ_STATUS, 8'h03);
    wr(OFS_STATUS_CTRL, 8'h12);
    cpu_halt <= 1'b1;
    b = 8'($urandom);
    m.start();
    send({7'h5A, 1'b0}, 8'h00); // Address seen while halted
    rd(OFS_STATUS_CTRL, 8'h40, 8'h44); // Write after a read
    send(b, 8'h00); // Reception while halted
    m.stop();
    cmp_irq(1'b1); // Interrupt while halted
    rd(OFS_DATA, b, 8'hFF); // Data kept
    m.start();
    send({7'h5A, 1'b1}, 8'h00); // Read address while halted
    recv(1'b1, 8'hFF); // No transmit while halted
    m.stop();
    wr(OFS_STATUS_CTRL, 8'h10);
    m.start();
    send({7'h5A, 1'b0}, 8'h01); // Ignored without own clock
    m.stop();
    cpu_halt <= 1'b0;
    repeat (4) @(posedge core_clk);
    close_out();
  end
endmodule : issc_top_test
